// >>> hw/lfp_ctrl.sv
// Operation
// - spin rate 600 or 1200 rpm, default 600, reported back
// - single last/strongest or dual return, coded in every packet
// - sequence numbering off, or counting only inside azimuth window
// - always-count setting advances sequence for every packet
// - phase lock puts rotor at target azimuth on each full second
// - satellite lock: pulse-per-second rising edge marks full second
// - time protocol tracking or locked: master time marks full second
// - otherwise internal once-per-second tick rising edge is used
// - angle trigger fires every 0.2 deg at 10 Hz, 0.4 at 20
// - time trigger, default, fires every 55.56 microseconds
// - noise filter off by default, drops isolated points when on
// - interstitial filter off by default, drops between-edge points
// - retro echo filter off by default, drops double-range points
// - linear reflectivity mapping by default, 0 to 255 percent
// - two nonlinear mappings boost low-reflectivity resolution
// - standby stops motor and all firing, normal otherwise
// - rpm equals frame rate in hertz times sixty
// - standby applies at once, other settings on save command
`timescale 1ns/1ns
`default_nettype none
module lfp_ctrl
(
   input wire logic mclk_in,
   input wire logic reset_in,
   input wire lfp_pkg::lfp_cfg_t cfg_in,
   input wire logic save_in,
   input wire logic standby_in,
   input wire logic gps_lock_in,
   input wire logic pps_in,
   input wire logic ptp_ok_in,
   input wire logic ptp_sec_in,
   input wire logic [11:0] azimuth_in,
   input wire logic pkt_in,
   input wire logic pkt_in_fov_in,
   output lfp_pkg::lfp_cfg_t cfg_out,
   output logic [10:0] rpm_out,
   output logic [4:0] frame_hz_out,
   output logic motor_run_out,
   output logic sec_evt_out,
   output logic [12:0] phase_err_out,
   output logic fire_out,
   output logic [1:0] ret_field_out,
   output logic seq_valid_out,
   output logic [15:0] seq_out,
   output logic standby_out
);

   function automatic logic [11:0] ang_add(input logic [11:0] a,
                                           input logic [11:0] b);
      logic [12:0] s;
      s = {1'b0, a} + {1'b0, b};
      if (s >= {1'b0, lfp_pkg::ANGLE_FULL})
      begin
         s = s - {1'b0, lfp_pkg::ANGLE_FULL};
      end
      return s[11:0];
   endfunction : ang_add

   // pin synchronisers
   logic [1:0] pps_s1_reg, pps_s1_next;
   logic [1:0] pps_s2_reg, pps_s2_next;
   logic [1:0] ptp_s1_reg, ptp_s1_next;
   logic [1:0] ptp_s2_reg, ptp_s2_next;
   logic pps_d_reg, pps_d_next;
   logic ptp_d_reg, ptp_d_next;
   // state
   lfp_pkg::lfp_cfg_t cfg_reg, cfg_next;
   logic stby_reg, stby_next;
   logic [24:0] sec_cnt_reg, sec_cnt_next;
   logic tick_reg, tick_next;
   logic tick_d_reg, tick_d_next;
   logic sec_reg, sec_next;
   logic [12:0] perr_reg, perr_next;
   logic [10:0] fcnt_reg, fcnt_next;
   logic [11:0] next_ang_reg, next_ang_next;
   logic fire_reg, fire_next;
   logic [15:0] seq_reg, seq_next;
   logic seq_v_reg, seq_v_next;
   logic [1:0] ret_reg, ret_next;
   logic [1:0] seq_prev_reg, seq_prev_next;
   logic [10:0] gap_reg, gap_next;

   logic pps_rise, ptp_rise, tick_rise, sec_evt;
   logic [11:0] step;

   always_comb
   begin
      pps_s1_next = {pps_s1_reg[0], pps_in};
      pps_s2_next = {pps_s2_reg[0], ptp_sec_in};
      ptp_s1_next = {ptp_s1_reg[0], gps_lock_in};
      ptp_s2_next = {ptp_s2_reg[0], ptp_ok_in};
      pps_d_next = pps_s1_reg[1];
      ptp_d_next = pps_s2_reg[1];
      pps_rise = pps_s1_reg[1] & ~pps_d_reg;
      ptp_rise = pps_s2_reg[1] & ~ptp_d_reg;
      tick_rise = tick_reg & ~tick_d_reg;
      // full second source priority
      if (ptp_s1_reg[1])
         sec_evt = pps_rise;
      else if (ptp_s2_reg[1])
         sec_evt = ptp_rise;
      else
         sec_evt = tick_rise;
   end

   // settings: standby at once, rest on save
   always_comb
   begin
      cfg_next = cfg_reg;
      if (save_in)
      begin
         cfg_next = cfg_in;
      end
      stby_next = standby_in;
   end

   // internal 1 Hz tick, high for half a second
   always_comb
   begin
      if (sec_cnt_reg == 25'(lfp_pkg::ONE_SEC_CYC - 1))
         sec_cnt_next = '0;
      else
         sec_cnt_next = sec_cnt_reg + 25'h0000001;
      tick_next = (sec_cnt_reg < 25'(lfp_pkg::ONE_SEC_CYC / 2));
      tick_d_next = tick_reg;
      sec_next = sec_evt;
   end

   // phase error at the full second, steers the motor loop
   always_comb
   begin
      perr_next = perr_reg;
      if (sec_evt && cfg_reg.sync_en && !stby_reg)
         perr_next = {1'b0, cfg_reg.sync_angle}
                     - {1'b0, azimuth_in};
      else if (!cfg_reg.sync_en)
         perr_next = '0;
   end

   // firing trigger
   always_comb
   begin
      step = cfg_reg.spin_high ? lfp_pkg::STEP_HIGH : lfp_pkg::STEP_LOW;
      fcnt_next = fcnt_reg;
      next_ang_next = next_ang_reg;
      fire_next = 1'b0;
      gap_next = (fire_out || stby_reg || cfg_reg.angle_trig) ? 11'h000
                 : gap_reg + {10'h000, gap_reg != 11'h7FF};
      if (stby_reg)
      begin
         fcnt_next = '0;
         next_ang_next = azimuth_in;
      end
      else if (cfg_reg.angle_trig)
      begin
         if (azimuth_in == next_ang_reg)
         begin
            fire_next = 1'b1;
            next_ang_next = ang_add(next_ang_reg, step);
         end
      end
      else if (fcnt_reg == 11'(lfp_pkg::FIRE_PERIOD_CYC - 1))
      begin
         fcnt_next = '0;
         fire_next = 1'b1;
      end
      else
      begin
         fcnt_next = fcnt_reg + 11'h001;
      end
   end

   // packet fields
   always_comb
   begin
      seq_next = seq_reg;
      seq_prev_next = cfg_reg.seq_mode;
      ret_next = cfg_reg.ret_mode;
      seq_v_next = (cfg_reg.seq_mode != lfp_pkg::LFP_SEQ_OFF);
      if (cfg_reg.seq_mode == lfp_pkg::LFP_SEQ_OFF
          || seq_prev_reg == lfp_pkg::LFP_SEQ_OFF)
      begin
         seq_next = lfp_pkg::RST_SEQ;
      end
      else if (pkt_in && (cfg_reg.seq_mode == lfp_pkg::LFP_SEQ_ALL
                          || pkt_in_fov_in))
      begin
         seq_next = seq_reg + 16'h0001;
      end
   end

   always_ff @(posedge mclk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         pps_s1_reg <= '0;
         pps_s2_reg <= '0;
         ptp_s1_reg <= '0;
         ptp_s2_reg <= '0;
         pps_d_reg <= 1'b0;
         ptp_d_reg <= 1'b0;
         cfg_reg <= lfp_pkg::RST_CFG;
         stby_reg <= 1'b0;
         sec_cnt_reg <= '0;
         tick_reg <= 1'b0;
         tick_d_reg <= 1'b0;
         sec_reg <= 1'b0;
         perr_reg <= '0;
         fcnt_reg <= '0;
         next_ang_reg <= '0;
         fire_reg <= 1'b0;
         seq_reg <= lfp_pkg::RST_SEQ;
         seq_v_reg <= 1'b0;
         ret_reg <= lfp_pkg::LFP_RET_LAST;
         seq_prev_reg <= lfp_pkg::LFP_SEQ_OFF;
         gap_reg <= 11'h000;
      end
      else
      begin
         pps_s1_reg <= pps_s1_next;
         pps_s2_reg <= pps_s2_next;
         ptp_s1_reg <= ptp_s1_next;
         ptp_s2_reg <= ptp_s2_next;
         pps_d_reg <= pps_d_next;
         ptp_d_reg <= ptp_d_next;
         cfg_reg <= cfg_next;
         stby_reg <= stby_next;
         sec_cnt_reg <= sec_cnt_next;
         tick_reg <= tick_next;
         tick_d_reg <= tick_d_next;
         sec_reg <= sec_next;
         perr_reg <= perr_next;
         fcnt_reg <= fcnt_next;
         next_ang_reg <= next_ang_next;
         fire_reg <= fire_next;
         seq_reg <= seq_next;
         seq_v_reg <= seq_v_next;
         ret_reg <= ret_next;
         seq_prev_reg <= seq_prev_next;
         gap_reg <= gap_next;
      end
   end

   // filters and mapping go out as settings for the point pipeline
   assign cfg_out = cfg_reg;
   assign rpm_out = cfg_reg.spin_high ? lfp_pkg::RPM_HIGH
                                      : lfp_pkg::RPM_LOW;
   assign frame_hz_out = cfg_reg.spin_high ? lfp_pkg::FRAME_HZ_HIGH
                                           : lfp_pkg::FRAME_HZ_LOW;
   assign motor_run_out = ~stby_reg;
   assign standby_out = stby_reg;
   assign sec_evt_out = sec_reg;
   assign phase_err_out = perr_reg;
   assign fire_out = fire_reg & ~stby_reg;
   assign ret_field_out = ret_reg;
   assign seq_valid_out = seq_v_reg;
   assign seq_out = seq_reg;

   property p_fire_period;
      @(posedge mclk_in) disable iff (reset_in)
      (fire_out && !cfg_reg.angle_trig && !stby_reg)
         |-> ##1 !fire_out [*8];
   endproperty
   a_fire_period: assert property (p_fire_period)
      else $error("time trigger fired too soon");

   property p_time_fire_due;
      @(posedge mclk_in) disable iff (reset_in)
      gap_reg <= 11'(lfp_pkg::FIRE_PERIOD_CYC);
   endproperty
   a_time_fire_due: assert property (p_time_fire_due)
      else $error("time trigger missed period");

   property p_standby_quiet;
      @(posedge mclk_in) disable iff (reset_in)
      stby_reg |-> (!fire_out && !motor_run_out);
   endproperty
   a_standby_quiet: assert property (p_standby_quiet)
      else $error("activity in standby");

   property p_standby_now;
      @(posedge mclk_in) disable iff (reset_in)
      standby_in |=> standby_out;
   endproperty
   a_standby_now: assert property (p_standby_now)
      else $error("standby not applied at once");

   property p_hold_without_save;
      @(posedge mclk_in) disable iff (reset_in)
      !save_in |=> $stable(cfg_out);
   endproperty
   a_hold_without_save: assert property (p_hold_without_save)
      else $error("setting changed without save");

   property p_rpm_frame;
      @(posedge mclk_in) disable iff (reset_in)
      rpm_out == 11'(frame_hz_out * lfp_pkg::RPM_PER_HZ);
   endproperty
   a_rpm_frame: assert property (p_rpm_frame)
      else $error("rpm not sixty times frame rate");

   property p_seq_off;
      @(posedge mclk_in) disable iff (reset_in)
      (cfg_reg.seq_mode == lfp_pkg::LFP_SEQ_OFF) |=> !seq_valid_out
         && seq_out == 16'h0000;
   endproperty
   a_seq_off: assert property (p_seq_off)
      else $error("sequence present while off");

   property p_seq_all;
      @(posedge mclk_in) disable iff (reset_in)
      (pkt_in && cfg_reg.seq_mode == lfp_pkg::LFP_SEQ_ALL
       && seq_prev_reg == lfp_pkg::LFP_SEQ_ALL)
         |=> seq_out == 16'($past(seq_out) + 16'h0001);
   endproperty
   a_seq_all: assert property (p_seq_all)
      else $error("sequence missed a packet");

   property p_seq_fov_hold;
      @(posedge mclk_in) disable iff (reset_in)
      (cfg_reg.seq_mode == lfp_pkg::LFP_SEQ_FOV && !pkt_in_fov_in
       && seq_prev_reg == lfp_pkg::LFP_SEQ_FOV) |=> $stable(seq_out);
   endproperty
   a_seq_fov_hold: assert property (p_seq_fov_hold)
      else $error("sequence counted outside window");

   property p_sec_int;
      @(posedge mclk_in) disable iff (reset_in)
      (!ptp_s1_reg[1] && !ptp_s2_reg[1] && tick_reg && !tick_d_reg)
         |=> sec_evt_out;
   endproperty
   a_sec_int: assert property (p_sec_int)
      else $error("internal tick not used as full second");

endmodule : lfp_ctrl
`default_nettype wire

// >>> hw/lfp_pkg.sv
package lfp_pkg;

   // spin rates and frame relation
   localparam logic [10:0] RPM_LOW = 11'h258;
   localparam logic [10:0] RPM_HIGH = 11'h4B0;
   localparam logic [5:0] RPM_PER_HZ = 6'h3C;
   localparam logic [4:0] FRAME_HZ_LOW = 5'h0A;
   localparam logic [4:0] FRAME_HZ_HIGH = 5'h14;

   // angles in 0.1 degree units, 0..3599
   localparam logic [11:0] ANGLE_FULL = 12'hE10;
   localparam logic [11:0] STEP_LOW = 12'h002;
   localparam logic [11:0] STEP_HIGH = 12'h004;

   // clock and time-based firing period
   localparam int CLK_HZ = 25000000;
   localparam int FIRE_PERIOD_NS = 55560;
   localparam int FIRE_PERIOD_CYC = (FIRE_PERIOD_NS * 25) / 1000;
   localparam int ONE_SEC_CYC = CLK_HZ;

   // settings after reset
   localparam logic RST_SPIN_HIGH = 1'b0;
   localparam logic RST_ANGLE_TRIG = 1'b0;
   localparam logic RST_FILTER = 1'b0;
   localparam logic [15:0] RST_SEQ = 16'h0000;

   typedef enum logic [1:0]
   {
      LFP_RET_LAST = 2'b00,
      LFP_RET_STRONG = 2'b01,
      LFP_RET_DUAL = 2'b10
   } lfp_ret_t;

   typedef enum logic [1:0]
   {
      LFP_SEQ_OFF = 2'b00,
      LFP_SEQ_FOV = 2'b01,
      LFP_SEQ_ALL = 2'b10
   } lfp_seq_t;

   typedef enum logic [1:0]
   {
      LFP_MAP_LIN = 2'b00,
      LFP_MAP_NL1 = 2'b01,
      LFP_MAP_NL2 = 2'b10
   } lfp_map_t;

   typedef struct packed
   {
      logic spin_high;
      lfp_ret_t ret_mode;
      lfp_seq_t seq_mode;
      logic sync_en;
      logic [11:0] sync_angle;
      logic angle_trig;
      logic noise_flt;
      logic inter_flt;
      logic retro_flt;
      lfp_map_t refl_map;
   } lfp_cfg_t;

   localparam lfp_cfg_t RST_CFG = '{RST_SPIN_HIGH, LFP_RET_LAST, LFP_SEQ_OFF,
      1'b0, 12'h000, RST_ANGLE_TRIG, RST_FILTER, RST_FILTER, RST_FILTER,
      LFP_MAP_LIN};

endpackage : lfp_pkg

// >>> testbench/lfp_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none
module lfp_ctrl_tb;
   logic mclk_in = 1'b0;
   logic reset_in = 1'b1;
   lfp_pkg::lfp_cfg_t cfg = lfp_pkg::RST_CFG;
   lfp_pkg::lfp_cfg_t cur = lfp_pkg::RST_CFG;
   logic save = 1'b0;
   logic stby = 1'b0;
   logic gps = 1'b0;
   logic ptp = 1'b0;
   logic az_run = 1'b0;
   logic [11:0] az = 12'h028;
   logic pps, psec, pkt, fov;
   lfp_pkg::lfp_cfg_t cfg_out;
   logic [10:0] rpm;
   logic [4:0] fhz;
   logic run, sec, fire, sval, sby;
   logic [12:0] perr;
   logic [1:0] ret;
   logic [15:0] seq;
   int n_fail = 0;
   int num_checks = 0;
   int n;

   always #20 mclk_in = ~mclk_in;
   // rotor turns one 0.1 degree step per cycle
   always @(posedge mclk_in)
      if (az_run)
         az <= (az == 12'hE0F) ? 12'h000 : az + 12'h001;

   lfp_ctrl uut
   (
      .mclk_in(mclk_in), .reset_in(reset_in), .cfg_in(cfg),
      .save_in(save), .standby_in(stby), .gps_lock_in(gps),
      .pps_in(pps), .ptp_ok_in(ptp), .ptp_sec_in(psec),
      .azimuth_in(az), .pkt_in(pkt), .pkt_in_fov_in(fov),
      .cfg_out(cfg_out), .rpm_out(rpm), .frame_hz_out(fhz),
      .motor_run_out(run), .sec_evt_out(sec), .phase_err_out(perr),
      .fire_out(fire), .ret_field_out(ret), .seq_valid_out(sval),
      .seq_out(seq), .standby_out(sby)
   );

   lfp_host_model host
   (
      .mclk_in(mclk_in), .pps_out(pps), .sec_out(psec),
      .pkt_out(pkt), .fov_out(fov)
   );

   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : summarize

   task automatic chk(input string s, input logic [31:0] got, exp);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] %s expected %0h seen %0h", s, exp, got);
      end
   endtask : chk

   task automatic apply(input lfp_pkg::lfp_cfg_t c);
      @(posedge mclk_in);
      cfg <= c;
      save <= 1'b1;
      @(posedge mclk_in);
      save <= 1'b0;
      @(negedge mclk_in);
      @(negedge mclk_in);
   endtask : apply

   task automatic wait_fire(output int c);
      c = 0;
      do
      begin
         @(negedge mclk_in);
         c++;
      end
      while (fire !== 1'b1 && c < 8000);
      if (c >= 8000)
      begin
         n_fail++;
         summarize();
      end
   endtask : wait_fire

   task automatic cnt_sec(input logic g, output int c);
      host.edge_sec(g);
      c = 0;
      repeat (16)
      begin
         @(negedge mclk_in);
         if (sec === 1'b1)
            c++;
      end
   endtask : cnt_sec

   task automatic t_reset;
      repeat (2) @(negedge mclk_in);
      chk("tick", 32'(sec), 32'h1);
      chk("cfg", 32'(cfg_out), 32'(lfp_pkg::RST_CFG));
      chk("rpm", 32'(rpm), 32'(lfp_pkg::RPM_LOW));
      chk("hz", 32'(fhz), 32'(lfp_pkg::FRAME_HZ_LOW));
      chk("run", 32'(run), 32'h1);
      chk("seq", 32'(seq), 32'h0);
      $display("reset test done");
   endtask : t_reset

   task automatic t_cfg;
      cur.spin_high = 1'b1;
      cur.noise_flt = 1'b1;
      cur.inter_flt = 1'b1;
      cur.retro_flt = 1'b1;
      @(posedge mclk_in);
      cfg <= cur;
      repeat (3) @(negedge mclk_in);
      chk("nosave", 32'(cfg_out), 32'(lfp_pkg::RST_CFG));
      apply(cur);
      chk("flt", 32'(cfg_out), 32'(cur));
      chk("rpm", 32'(rpm), 32'(lfp_pkg::RPM_HIGH));
      chk("hz", 32'(fhz), 32'(lfp_pkg::FRAME_HZ_HIGH));
      for (int i = 0; i < 3; i++)
      begin
         cur.ret_mode = lfp_pkg::lfp_ret_t'(i);
         cur.refl_map = lfp_pkg::lfp_map_t'(i);
         apply(cur);
         chk("ret", 32'(ret), 32'(cur.ret_mode));
         chk("map", 32'(cfg_out.refl_map), 32'(cur.refl_map));
      end
      cur = lfp_pkg::RST_CFG;
      apply(cur);
      $display("settings test done");
   endtask : t_cfg

   task automatic t_trig;
      wait_fire(n);
      wait_fire(n);
      chk("tper", 32'(n), 32'(lfp_pkg::FIRE_PERIOD_CYC));
      az_run <= 1'b1;
      cur.angle_trig = 1'b1;
      for (int i = 0; i < 2; i++)
      begin
         cur.spin_high = i[0];
         apply(cur);
         wait_fire(n);
         wait_fire(n);
         chk("aper", 32'(n), 32'(i ? 4 : 2));
      end
      cur = lfp_pkg::RST_CFG;
      apply(cur);
      az_run <= 1'b0;
      $display("trigger test done");
   endtask : t_trig

   task automatic t_stby;
      @(posedge mclk_in);
      stby <= 1'b1;
      @(posedge mclk_in);
      @(negedge mclk_in);
      chk("sby", 32'(sby), 32'h1);
      chk("run", 32'(run), 32'h0);
      n = 0;
      repeat (3000)
      begin
         @(negedge mclk_in);
         if (fire === 1'b1)
            n++;
      end
      chk("fires", 32'(n), 32'h0);
      @(posedge mclk_in);
      stby <= 1'b0;
      wait_fire(n);
      chk("run", 32'(run), 32'h1);
      $display("standby test done");
   endtask : t_stby

   task automatic t_seq;
      cur.seq_mode = lfp_pkg::LFP_SEQ_ALL;
      apply(cur);
      chk("sval", 32'(sval), 32'h1);
      host.pkts(5, 1'b0);
      @(negedge mclk_in);
      chk("seq", 32'(seq), 32'h5);
      cur.seq_mode = lfp_pkg::LFP_SEQ_OFF;
      apply(cur);
      chk("sval", 32'(sval), 32'h0);
      cur.seq_mode = lfp_pkg::LFP_SEQ_FOV;
      apply(cur);
      chk("seq", 32'(seq), 32'h0);
      host.pkts(3, 1'b0);
      host.pkts(4, 1'b1);
      @(negedge mclk_in);
      chk("seq", 32'(seq), 32'h4);
      $display("sequence test done");
   endtask : t_seq

   task automatic t_sec;
      cur.sync_en = 1'b1;
      cur.sync_angle = 12'h064;
      @(posedge mclk_in);
      az <= 12'h028;
      apply(cur);
      @(posedge mclk_in);
      gps <= 1'b1;
      ptp <= 1'b1;
      repeat (6) @(negedge mclk_in);
      cnt_sec(1'b0, n);
      chk("ptpign", 32'(n), 32'h0);
      cnt_sec(1'b1, n);
      chk("pps", 32'(n), 32'h1);
      chk("perr", 32'(perr), 32'h3C);
      @(posedge mclk_in);
      gps <= 1'b0;
      repeat (6) @(negedge mclk_in);
      cnt_sec(1'b0, n);
      chk("ptp", 32'(n), 32'h1);
      @(posedge mclk_in);
      ptp <= 1'b0;
      repeat (6) @(negedge mclk_in);
      cnt_sec(1'b1, n);
      chk("ppsign", 32'(n), 32'h0);
      $display("second test done");
   endtask : t_sec

   initial
   begin
      repeat (5) @(posedge mclk_in);
      reset_in <= 1'b0;
      @(negedge mclk_in);
      t_reset();
      t_cfg();
      t_trig();
      t_stby();
      t_seq();
      t_sec();
      summarize();
   end
endmodule : lfp_ctrl_tb
`default_nettype wire

// >>> testbench/lfp_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module lfp_host_model
(
   input wire logic mclk_in,
   output logic pps_out,
   output logic sec_out,
   output logic pkt_out,
   output logic fov_out
);
   initial
   begin
      pps_out = 1'b0;
      sec_out = 1'b0;
      pkt_out = 1'b0;
      fov_out = 1'b0;
   end

   // second mark: satellite pulse or time-master second
   task automatic edge_sec(input logic gps);
      @(posedge mclk_in);
      pps_out <= gps;
      sec_out <= ~gps;
      repeat (3) @(posedge mclk_in);
      pps_out <= 1'b0;
      sec_out <= 1'b0;
   endtask : edge_sec

   task automatic pkts(input int cnt, input logic in_win);
      repeat (cnt)
      begin
         @(posedge mclk_in);
         pkt_out <= 1'b1;
         fov_out <= in_win;
         @(posedge mclk_in);
         pkt_out <= 1'b0;
         fov_out <= ~in_win;
      end
   endtask : pkts
endmodule : lfp_host_model
`default_nettype wire
